// file: dprt_pkg.sv
// shared constants of the dual prescaled reload timer
package dprt_pkg;

  // ----------------------------------------------------------------
  // prescaler ratio codes and divide factors
  // ----------------------------------------------------------------
  localparam logic [1:0] DPRT_RATIO_DIV1   = 2'h0;
  localparam logic [1:0] DPRT_RATIO_DIV4   = 2'h1;
  localparam logic [1:0] DPRT_RATIO_DIV32  = 2'h2;
  localparam logic [1:0] DPRT_RATIO_DIV256 = 2'h3;
  localparam int         DPRT_DIV1         = 1;
  localparam int         DPRT_DIV4         = 4;
  localparam int         DPRT_DIV32        = 32;
  localparam int         DPRT_DIV256       = 256;

  // ----------------------------------------------------------------
  // source select, edge polarity and pulse channel encodings
  // ----------------------------------------------------------------
  localparam logic DPRT_SRC_LOW_SPEED  = 1'b0;
  localparam logic DPRT_SRC_HIGH_SPEED = 1'b1;
  localparam logic DPRT_POL_FALLING    = 1'b0;
  localparam logic DPRT_CH_TIMER0      = 1'b0;

  // ----------------------------------------------------------------
  // reset values and noise rejector
  // ----------------------------------------------------------------
  localparam logic [7:0] DPRT_COUNT_RST   = 8'h00;
  localparam logic [7:0] DPRT_DIV_CNT_RST = 8'h00;
  localparam logic       DPRT_TOGGLE_RST  = 1'b0;
  localparam logic       DPRT_FLAG_RST    = 1'b0;
  localparam int         DPRT_FILTER_EDGES = 2;

endpackage

// file: dprt_prescaler.sv
// one prescaler: divides source clock edges by 1, 4, 32 or 256
`timescale 1ns/1ps
module dprt_prescaler
  import dprt_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic       i_src_edge,
  input  wire logic [1:0] i_ratio,
  output logic            o_tick
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DIV_W < 8) begin : g_bad_width
    $error("dprt_prescaler: DIV_W must hold a divide by 256");
  end

  // ----------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------
  function automatic logic [DIV_W-1:0] ratio_limit(input logic [1:0] r);
    logic [DIV_W-1:0] lim;
    lim = '0;
    case (r)
      DPRT_RATIO_DIV256: lim = DIV_W'(DPRT_DIV256 - 1);
      DPRT_RATIO_DIV32:  lim = DIV_W'(DPRT_DIV32 - 1);
      DPRT_RATIO_DIV4:   lim = DIV_W'(DPRT_DIV4 - 1);
      default:           lim = DIV_W'(DPRT_DIV1 - 1);
    endcase
    return lim;
  endfunction

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  wire  logic       at_limit;

  assign at_limit = (cnt_q >= ratio_limit(i_ratio));
  assign o_tick   = i_run & i_src_edge & at_limit;
  // a stopped prescaler restarts from zero so the first period is whole
  assign cnt_d    = !i_run     ? '0 :
                    !i_src_edge ? cnt_q :
                    at_limit   ? '0 : cnt_q + DIV_W'(1);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_q <= DIV_W'(DPRT_DIV_CNT_RST);
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// file: dprt_timer.sv
// dual 8-bit reload timer with chaining, event counting and pulse output
//
// Functional notes
// - each prescaler takes low-speed source on 0, high-speed on 1
// - ratio code 11 /256, 10 /32, 01 /4, 00 /1
// - in event mode timer 0 ignores its source and ratio settings
// - run bit starts the prescaler; counter decrements per divided pulse
// - underflow sets flag regardless of mask; irq only when enabled
// - pulse output toggles on each underflow of the chosen timer
// - channel select 0 picks timer 0 (timer 1 in width mode), 1 picks timer 1
// - with latch input high: gate 1 drives pulse on pin, gate 0 holds pin high
// - gate acts asynchronously so a half-cycle glitch may appear
// - halved timer 1 underflow is the serial clock while running
// - timer 1 reload of zero underflows every prescaled clock
// - width mode chains timers: timer 0 low byte, timer 1 high
// - reload strobe loads the counter from its reload value
// - in 16-bit mode timer 0 run bit alone starts and stops both
// - reading low byte holds high byte; software reads low first
// - underflow reloads and keeps counting; drives flag and pulse, and serial for timer 1 only
// - event mode bit makes timer 0 count event pin edges
// - after reset the counter mode is timer mode
// - event polarity 0 counts falling edges, 1 rising edges
// - noise rejector accepts change at second 2048 Hz falling edge
`timescale 1ns/1ps
module dprt_timer
  import dprt_pkg::*;
#(
  parameter int FILTER_EDGES = DPRT_FILTER_EDGES
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_low_speed_oscillator,
  input  wire logic       i_high_speed_oscillator,
  input  wire logic       i_clk_2048,
  input  wire logic       i_event_input_pin,
  input  wire logic       i_t0_source_select,
  input  wire logic       i_t1_source_select,
  input  wire logic       i_t0_divider_bit_lo,
  input  wire logic       i_t0_divider_bit_hi,
  input  wire logic       i_t1_divider_bit_lo,
  input  wire logic       i_t1_divider_bit_hi,
  input  wire logic       i_t0_run_bit,
  input  wire logic       i_t1_run_bit,
  input  wire logic       i_t0_reload_strobe,
  input  wire logic       i_t1_reload_strobe,
  input  wire logic [7:0] i_t0_reload_bits,
  input  wire logic [7:0] i_t1_reload_bits,
  input  wire logic       i_width_mode_bit,
  input  wire logic       i_event_mode_bit,
  input  wire logic       i_edge_polarity_bit,
  input  wire logic       i_noise_filter_bit,
  input  wire logic       i_t0_flag_clear,
  input  wire logic       i_t1_flag_clear,
  input  wire logic       i_t0_irq_enable,
  input  wire logic       i_t1_irq_enable,
  input  wire logic       i_pulse_channel_select,
  input  wire logic       i_pulse_out_gate,
  input  wire logic       i_shared_output_pin,
  input  wire logic       i_low_byte_read,
  input  wire logic       i_high_byte_read,
  output logic [7:0]      o_t0_count_readback,
  output logic [7:0]      o_t1_count_readback,
  output logic            o_t0_underflow_flag,
  output logic            o_t1_underflow_flag,
  output logic            o_t0_irq,
  output logic            o_t1_irq,
  output logic            o_pulse_out,
  output logic            o_shared_output_pin,
  output logic            o_serial_clock
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (FILTER_EDGES < 1 || FILTER_EDGES > 3) begin : g_bad_filter
    $error("dprt_timer: FILTER_EDGES must be 1 to 3");
  end

  typedef enum logic [1:0] {
    DPRT_FLT_STABLE,
    DPRT_FLT_PENDING
  } dprt_flt_e;

  function automatic logic [7:0] dec8(input logic [7:0] v);
    return v - 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // source edges
  // ----------------------------------------------------------------
  logic ls_q;
  logic hs_q;
  logic c2k_q;
  wire  logic ls_edge;
  wire  logic hs_edge;
  wire  logic c2k_fall;
  wire  logic src0_edge;
  wire  logic src1_edge;

  assign ls_edge   = i_low_speed_oscillator & ~ls_q;
  assign hs_edge   = i_high_speed_oscillator & ~hs_q;
  assign c2k_fall  = ~i_clk_2048 & c2k_q;
  // high-speed edges only arrive once software has settled it
  assign src0_edge = (i_t0_source_select == DPRT_SRC_HIGH_SPEED) ?
                     hs_edge : ls_edge;
  assign src1_edge = (i_t1_source_select == DPRT_SRC_HIGH_SPEED) ?
                     hs_edge : ls_edge;

  // ----------------------------------------------------------------
  // prescalers
  // ----------------------------------------------------------------
  wire logic p0_run;
  wire logic p1_run;
  wire logic p0_tick;
  wire logic p1_tick;

  // prescaler 0 idles in event mode, timer 1's in chained mode
  assign p0_run = i_t0_run_bit & ~i_event_mode_bit;
  assign p1_run = i_t1_run_bit & ~i_width_mode_bit;

  dprt_prescaler u_presc0 (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_run      (p0_run),
    .i_src_edge (src0_edge),
    .i_ratio    ({i_t0_divider_bit_hi, i_t0_divider_bit_lo}),
    .o_tick     (p0_tick)
  );

  dprt_prescaler u_presc1 (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_run      (p1_run),
    .i_src_edge (src1_edge),
    .i_ratio    ({i_t1_divider_bit_hi, i_t1_divider_bit_lo}),
    .o_tick     (p1_tick)
  );

  // ----------------------------------------------------------------
  // event input and noise rejector
  // ----------------------------------------------------------------
  dprt_flt_e  flt_q;
  dprt_flt_e  flt_d;
  logic [1:0] fedge_q;
  logic [1:0] fedge_d;
  logic       lvl_q;
  logic       lvl_d;
  logic       lvl_prev_q;
  wire  logic differs;
  wire  logic accept;
  wire  logic evt_edge;

  assign differs = i_event_input_pin ^ lvl_q;
  assign accept  = (flt_q == DPRT_FLT_PENDING) & differs & c2k_fall &
                   (fedge_q == 2'(FILTER_EDGES - 1));

  always_comb begin
    flt_d   = flt_q;
    fedge_d = fedge_q;
    lvl_d   = lvl_q;
    case (flt_q)
      DPRT_FLT_STABLE: begin
        fedge_d = 2'h0;
        if (differs && !i_noise_filter_bit) begin
          lvl_d = i_event_input_pin;
        end else if (differs) begin
          flt_d = DPRT_FLT_PENDING;
        end
      end
      DPRT_FLT_PENDING: begin
        // a pulse that returns before acceptance is thrown away
        if (!differs || !i_noise_filter_bit) begin
          flt_d = DPRT_FLT_STABLE;
        end else if (accept) begin
          lvl_d = i_event_input_pin;
          flt_d = DPRT_FLT_STABLE;
        end else if (c2k_fall) begin
          fedge_d = fedge_q + 2'h1;
        end
      end
      default: flt_d = DPRT_FLT_STABLE;
    endcase
  end

  assign evt_edge = (i_edge_polarity_bit == DPRT_POL_FALLING) ?
                    (lvl_prev_q & ~lvl_q) :
                    (~lvl_prev_q & lvl_q);

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  logic [7:0] cnt0_q;
  logic [7:0] cnt1_q;
  logic [7:0] cnt0_d;
  logic [7:0] cnt1_d;
  wire  logic tick0;
  wire  logic tick1;
  wire  logic z0;
  wire  logic z1;
  wire  logic uf0;
  wire  logic uf1;
  wire  logic reload0;

  assign z0    = (cnt0_q == 8'h00);
  assign z1    = (cnt1_q == 8'h00);
  assign tick0 = i_t0_run_bit &
                 (i_event_mode_bit ? evt_edge : p0_tick);
  // chained: the low byte's borrow clocks the high byte
  assign tick1 = i_width_mode_bit ? (tick0 & z0) : p1_tick;
  assign uf0   = ~i_width_mode_bit & tick0 & z0;
  assign uf1   = tick1 & z1;
  assign reload0 = i_width_mode_bit ? uf1 : uf0;

  assign cnt0_d = i_t0_reload_strobe ? i_t0_reload_bits :
                  reload0            ? i_t0_reload_bits :
                  tick0              ? dec8(cnt0_q) : cnt0_q;
  // a zero reload value simply underflows on every tick
  assign cnt1_d = i_t1_reload_strobe ? i_t1_reload_bits :
                  uf1                ? i_t1_reload_bits :
                  tick1              ? dec8(cnt1_q) : cnt1_q;

  // ----------------------------------------------------------------
  // flags, toggles and readback hold
  // ----------------------------------------------------------------
  logic       tog_q;
  logic       ser_q;
  logic       hold_q;
  logic [7:0] hi_q;
  wire  logic pulse_ev;

  // chained mode has one underflow, reported on timer 1
  assign pulse_ev = (i_pulse_channel_select != DPRT_CH_TIMER0 ||
                     i_width_mode_bit) ? uf1 : uf0;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ls_q       <= i_low_speed_oscillator;
      hs_q       <= i_high_speed_oscillator;
      c2k_q      <= i_clk_2048;
      flt_q      <= DPRT_FLT_STABLE;
      fedge_q    <= 2'h0;
      lvl_q      <= i_event_input_pin;
      lvl_prev_q <= i_event_input_pin;
      cnt0_q     <= DPRT_COUNT_RST;
      cnt1_q     <= DPRT_COUNT_RST;
      tog_q      <= DPRT_TOGGLE_RST;
      ser_q      <= DPRT_TOGGLE_RST;
      hold_q     <= 1'b0;
      hi_q       <= DPRT_COUNT_RST;
      o_t0_underflow_flag <= DPRT_FLAG_RST;
      o_t1_underflow_flag <= DPRT_FLAG_RST;
      o_t0_count_readback <= DPRT_COUNT_RST;
    end else begin
      ls_q       <= i_low_speed_oscillator;
      hs_q       <= i_high_speed_oscillator;
      c2k_q      <= i_clk_2048;
      flt_q      <= flt_d;
      fedge_q    <= fedge_d;
      lvl_q      <= lvl_d;
      lvl_prev_q <= lvl_q;
      cnt0_q     <= cnt0_d;
      cnt1_q     <= cnt1_d;
      if (pulse_ev) begin
        tog_q <= ~tog_q;
      end
      if (uf1) begin
        ser_q <= ~ser_q;
      end
      // set beats a simultaneous clear
      o_t0_underflow_flag <= uf0 |
        (o_t0_underflow_flag & ~i_t0_flag_clear);
      o_t1_underflow_flag <= uf1 |
        (o_t1_underflow_flag & ~i_t1_flag_clear);
      o_t0_count_readback <= cnt0_d;
      if (i_low_byte_read) begin
        hold_q <= 1'b1;
        hi_q   <= cnt1_q;
      end else begin
        if (i_high_byte_read) begin
          hold_q <= 1'b0;
        end
        if (!hold_q || i_high_byte_read) begin
          hi_q <= cnt1_d;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_t1_count_readback = hi_q;
  assign o_t0_irq       = o_t0_underflow_flag & i_t0_irq_enable;
  assign o_t1_irq       = o_t1_underflow_flag & i_t1_irq_enable;
  assign o_pulse_out    = tog_q;
  assign o_serial_clock = ser_q;
  // the gate is not timed to the toggle, so switching it may clip a
  // half cycle; the latch input must stay high for the pulse to pass
  assign o_shared_output_pin = i_shared_output_pin &
    (i_pulse_out_gate ? tog_q : 1'b1);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  property p_reload_on_uf;
    uf0 && !i_t0_reload_strobe |=> cnt0_q == $past(i_t0_reload_bits);
  endproperty
  a_reload_on_uf: assert property (p_reload_on_uf)
    else $error("timer 0 did not reload on underflow");

  property p_flag_set;
    uf1 |=> o_t1_underflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("timer 1 flag not set by underflow");

  property p_irq_masked;
    !i_t0_irq_enable |-> !o_t0_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("masked timer 0 raised an interrupt");

  property p_toggle;
    pulse_ev |=> o_pulse_out != $past(o_pulse_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pulse output did not toggle on underflow");

  property p_pin_high;
    !i_pulse_out_gate && i_shared_output_pin |-> o_shared_output_pin;
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("ungated pin not held high");

  property p_strobe_load;
    i_t1_reload_strobe |=> cnt1_q == $past(i_t1_reload_bits);
  endproperty
  a_strobe_load: assert property (p_strobe_load)
    else $error("reload strobe did not load timer 1");

  property p_chain_stop;
    i_width_mode_bit && !i_t0_run_bit && !i_t0_reload_strobe &&
      !i_t1_reload_strobe |=> $stable(cnt0_q) && $stable(cnt1_q);
  endproperty
  a_chain_stop: assert property (p_chain_stop)
    else $error("stopped chain changed its count");

  property p_chain_borrow;
    i_width_mode_bit && tick0 && z0 && !z1 && !i_t1_reload_strobe
      |=> cnt1_q == $past(cnt1_q) - 8'h01;
  endproperty
  a_chain_borrow: assert property (p_chain_borrow)
    else $error("low byte borrow did not decrement high byte");

  property p_event_only;
    i_event_mode_bit && !evt_edge && !i_t0_reload_strobe
      |=> $stable(cnt0_q);
  endproperty
  a_event_only: assert property (p_event_only)
    else $error("event mode counted without an event edge");

  property p_hold;
    hold_q && !i_high_byte_read && !i_low_byte_read
      |=> $stable(o_t1_count_readback);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held high byte changed before it was read");

  property p_filter_time;
    i_noise_filter_bit && $past(i_noise_filter_bit) && $changed(lvl_q)
      |-> $past(c2k_fall);
  endproperty
  a_filter_time: assert property (p_filter_time)
    else $error("filtered level moved off a 2048 Hz falling edge");

  property p_serial;
    !uf1 |=> $stable(o_serial_clock);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial clock moved without a timer 1 underflow");

  c_chain_uf: cover property (i_width_mode_bit && uf1);
  c_event_uf: cover property (i_event_mode_bit && uf0);
  c_filter_accept: cover property (i_noise_filter_bit && accept);
  c_zero_reload: cover property (uf1 ##1 uf1);

endmodule

// file: test_dual_prescaled_reload_timer.sv
// self-checking testbench of the dual prescaled reload timer
`timescale 1ns/1ps
module test_dual_prescaled_reload_timer
  import dprt_pkg::*;
;
  localparam int LIMIT = 40000;
  logic       i_mclk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       osc_lo, osc_hi, clk2k, ev_pin, sel0, sel1, run0, run1;
  logic       ld0, ld1, wide, evm, pol, nf, clr0, clr1, ie0, ie1;
  logic       pulse_channel_select, gate, latch, rd_lo, rd_hi;
  logic [1:0] r0, r1;
  logic [7:0] rl0, rl1, c0, c1;
  logic       f0, f1, q0, q1, pulse, pin, sclk, p, s;
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         cycles = 0;

  always #2.5 i_mclk = ~i_mclk;

  dprt_timer u_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_low_speed_oscillator(osc_lo), .i_high_speed_oscillator(osc_hi),
    .i_clk_2048(clk2k), .i_event_input_pin(ev_pin),
    .i_t0_source_select(sel0), .i_t1_source_select(sel1),
    .i_t0_divider_bit_lo(r0[0]), .i_t0_divider_bit_hi(r0[1]),
    .i_t1_divider_bit_lo(r1[0]), .i_t1_divider_bit_hi(r1[1]),
    .i_t0_run_bit(run0), .i_t1_run_bit(run1),
    .i_t0_reload_strobe(ld0), .i_t1_reload_strobe(ld1),
    .i_t0_reload_bits(rl0), .i_t1_reload_bits(rl1),
    .i_width_mode_bit(wide), .i_event_mode_bit(evm),
    .i_edge_polarity_bit(pol), .i_noise_filter_bit(nf),
    .i_t0_flag_clear(clr0), .i_t1_flag_clear(clr1),
    .i_t0_irq_enable(ie0), .i_t1_irq_enable(ie1),
    .i_pulse_channel_select(pulse_channel_select), .i_pulse_out_gate(gate),
    .i_shared_output_pin(latch), .i_low_byte_read(rd_lo),
    .i_high_byte_read(rd_hi),
    .o_t0_count_readback(c0), .o_t1_count_readback(c1),
    .o_t0_underflow_flag(f0), .o_t1_underflow_flag(f1),
    .o_t0_irq(q0), .o_t1_irq(q1), .o_pulse_out(pulse),
    .o_shared_output_pin(pin), .o_serial_clock(sclk)
  );

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // source edges spaced well below half the system clock rate
  task automatic osc_edge(input logic hi, input int n);
    repeat (n) begin
      if (hi) osc_hi = 1'b1; else osc_lo = 1'b1;
      step(3);
      if (hi) osc_hi = 1'b0; else osc_lo = 1'b0;
      step(3);
    end
  endtask

  task automatic fall_2k(input int n);
    repeat (n) begin
      clk2k = 1'b1;
      step(3);
      clk2k = 1'b0;
      step(3);
    end
  endtask

  task automatic load(input logic [7:0] a, input logic [7:0] b);
    rl0 = a;
    rl1 = b;
    ld0 = 1'b1;
    ld1 = 1'b1;
    step(1);
    ld0 = 1'b0;
    ld1 = 1'b0;
    step(2);
  endtask

  task automatic clear_flags();
    clr0 = 1'b1;
    clr1 = 1'b1;
    step(1);
    clr0 = 1'b0;
    clr1 = 1'b0;
    step(1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(c0, DPRT_COUNT_RST, "count0 reset");
    check(c1, DPRT_COUNT_RST, "count1 reset");
    check({f0, f1, q0, q1}, 8'h00, "flags reset");
    check({pulse, sclk}, 8'h00, "toggles reset");
    check(pin, 8'h01, "pin idle high");
    $display("test reset done");
  endtask

  task automatic t_serial();
    sel1 = DPRT_SRC_LOW_SPEED;
    r1 = DPRT_RATIO_DIV1;
    load(8'h00, 8'h00);
    run1 = 1'b1;
    osc_edge(1'b0, 1);
    check(f1, 8'h01, "flag1 on zero reload");
    check(q1, 8'h00, "irq1 masked");
    check(sclk, 8'h01, "serial clock toggled");
    check(c1, 8'h00, "count1 reloaded");
    ie1 = 1'b1;
    step(1);
    check(q1, 8'h01, "irq1 enabled");
    clear_flags();
    check(f1, 8'h00, "flag1 cleared");
    osc_edge(1'b0, 1);
    check(sclk, 8'h00, "serial clock halves");
    run1 = 1'b0;
    ie1 = 1'b0;
    clear_flags();
    $display("test serial done");
  endtask

  task automatic t_ratio();
    int div [4] = '{DPRT_DIV1, DPRT_DIV4, DPRT_DIV32, DPRT_DIV256};
    for (int k = 0; k < 4; k++) begin
      r0 = k[1:0];
      sel0 = DPRT_SRC_LOW_SPEED;
      load(8'h05, 8'h00);
      check(c0, 8'h05, "reload strobe");
      run0 = 1'b1;
      osc_edge(1'b1, 2 * div[k]);
      check(c0, 8'h05, "unselected source");
      osc_edge(1'b0, 2 * div[k]);
      check(c0, 8'h03, "divided count");
      run0 = 1'b0;
      step(1);
    end
    // high-speed source is treated as settled before it is used
    sel0 = DPRT_SRC_HIGH_SPEED;
    r0 = DPRT_RATIO_DIV1;
    run0 = 1'b1;
    osc_edge(1'b1, 2);
    check(c0, 8'h01, "high-speed source");
    run0 = 1'b0;
    clear_flags();
    $display("test ratio done");
  endtask

  task automatic t_pulse();
    r0 = DPRT_RATIO_DIV1;
    sel0 = DPRT_SRC_LOW_SPEED;
    pulse_channel_select = DPRT_CH_TIMER0;
    load(8'h00, 8'h00);
    run0 = 1'b1;
    p = pulse;
    osc_edge(1'b0, 1);
    check(pulse, {7'h0, ~p}, "pulse toggles on t0");
    check(pin, 8'h01, "gate off pin high");
    gate = 1'b1;
    step(1);
    check(pin, {7'h0, pulse}, "gate on pin drives");
    osc_edge(1'b0, 1);
    check(pin, 8'h00, "gate on pin follows low");
    pulse_channel_select = 1'b1;
    clear_flags();
    p = pulse;
    osc_edge(1'b0, 1);
    check(pulse, {7'h0, p}, "channel t1 ignores t0");
    check(f0, 8'h01, "flag0 without mask");
    check(q0, 8'h00, "irq0 masked");
    ie0 = 1'b1;
    step(1);
    check(q0, 8'h01, "irq0 enabled");
    ie0 = 1'b0;
    run1 = 1'b1;
    osc_edge(1'b0, 1);
    check(pulse, {7'h0, ~p}, "channel t1 toggles");
    run0 = 1'b0;
    run1 = 1'b0;
    gate = 1'b0;
    pulse_channel_select = DPRT_CH_TIMER0;
    clear_flags();
    $display("test pulse done");
  endtask

  task automatic t_wide();
    wide = 1'b1;
    load(8'h02, 8'h00);
    run0 = 1'b1;
    s = sclk;
    p = pulse;
    osc_edge(1'b0, 2);
    check({c1, c0} == 16'h0000, 8'h01, "chain at zero");
    check(f1, 8'h00, "no early underflow");
    osc_edge(1'b0, 1);
    check(f1, 8'h01, "chain underflow flag1");
    check(f0, 8'h00, "no flag0 in chain");
    check(c0, 8'h02, "chain reload low");
    check(sclk, {7'h0, ~s}, "chain serial toggle");
    check(pulse, {7'h0, ~p}, "chain pulse toggle");
    load(8'h00, 8'h01);
    osc_edge(1'b0, 1);
    check(c0, 8'hff, "borrow low byte");
    check(c1, 8'h00, "borrow high byte");
    run0 = 1'b0;
    run1 = 1'b1;
    osc_edge(1'b0, 3);
    check(c0, 8'hff, "stop keeps count");
    run1 = 1'b0;
    wide = 1'b0;
    clear_flags();
    $display("test wide done");
  endtask

  task automatic t_hold();
    r1 = DPRT_RATIO_DIV1;
    load(8'h00, 8'h05);
    run1 = 1'b1;
    rd_lo = 1'b1;
    step(1);
    rd_lo = 1'b0;
    osc_edge(1'b0, 1);
    check(c1, 8'h05, "high byte held");
    rd_hi = 1'b1;
    step(1);
    rd_hi = 1'b0;
    step(2);
    check(c1, 8'h04, "high byte released");
    run1 = 1'b0;
    $display("test hold done");
  endtask

  task automatic t_event();
    evm = 1'b1;
    pol = DPRT_POL_FALLING;
    r0 = DPRT_RATIO_DIV1;
    sel0 = DPRT_SRC_HIGH_SPEED;
    load(8'h05, 8'h00);
    run0 = 1'b1;
    osc_edge(1'b1, 2);
    check(c0, 8'h05, "source ignored");
    ev_pin = 1'b0;
    step(6);
    check(c0, 8'h04, "falling edge counted");
    ev_pin = 1'b1;
    step(6);
    check(c0, 8'h04, "rising edge ignored");
    pol = 1'b1;
    ev_pin = 1'b0;
    step(6);
    ev_pin = 1'b1;
    step(6);
    check(c0, 8'h03, "rising edge counted");
    pol = DPRT_POL_FALLING;
    nf = 1'b1;
    ev_pin = 1'b0;
    fall_2k(1);
    ev_pin = 1'b1;
    fall_2k(2);
    check(c0, 8'h03, "short pulse rejected");
    ev_pin = 1'b0;
    fall_2k(1);
    check(c0, 8'h03, "one edge not enough");
    fall_2k(1);
    step(4);
    check(c0, 8'h02, "second edge accepts");
    run0 = 1'b0;
    evm = 1'b0;
    nf = 1'b0;
    $display("test event done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    {osc_lo, osc_hi, clk2k, sel0, sel1, run0, run1} = 7'h00;
    {ld0, ld1, wide, evm, pol, nf, clr0, clr1} = 8'h00;
    {ie0, ie1, pulse_channel_select, gate, rd_lo, rd_hi} = 6'h00;
    {r0, r1, rl0, rl1} = 20'h00000;
    ev_pin = 1'b1;
    latch = 1'b1;
    step(20);
    i_rst_n = 1'b1;
    step(1);
    t_reset();
    t_serial();
    t_ratio();
    t_pulse();
    t_wide();
    t_hold();
    t_event();
    report_and_stop();
  end
endmodule
